/* rtl/aise_pkg.sv */
// Package with register map, field positions and reset values of the ADC interrupt block
package aise_pkg;
    // Register indices; byte address is four times the index
    localparam int IDX_W = 14;
    localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 14'h050f;
    localparam logic [IDX_W-1:0] IDX_EVENT_FLAGS = 14'h0510;
    localparam logic [IDX_W-1:0] IDX_FLAG_MASK = 14'h0520;
    localparam logic [IDX_W-1:0] IDX_SELFTEST_STATUS = 14'h0521;

    localparam int REG_W = 8;

    // Enable register fields
    localparam int BIT_REF_LIMIT_IRQ_EN = 6;
    localparam int BIT_REF_LIMIT_SCALE1_IRQ_EN = 5;
    localparam int BIT_REF_LIMIT_SCALE2_IRQ_EN = 4;
    localparam int BIT_REF_LIMIT_SCALE3_IRQ_EN = 3;
    localparam int BIT_TEMP_SENSOR_ERROR_IRQ_EN = 1;
    localparam logic [REG_W-1:0] ENABLE_VALID = 8'h7a;
    localparam logic [REG_W-1:0] ENABLE_RST = 8'h00;

    // Event flag register fields
    localparam int BIT_CALIBRATION_COMPLETE = 7;
    localparam int BIT_INPUT_OUT_OF_RANGE = 6;
    localparam int BIT_TEMP_CAL_OUT_OF_DATE = 5;
    localparam int BIT_LOW_THRESHOLD = 3;
    localparam int BIT_HIGH_THRESHOLD = 2;
    localparam int BIT_REF_READY = 1;
    localparam int BIT_CONVERSION_DONE = 0;
    localparam logic [REG_W-1:0] FLAGS_VALID = 8'hef;
    localparam logic [REG_W-1:0] FLAGS_RST = 8'h00;
    localparam logic [REG_W-1:0] FLAG_MASK_RST = 8'h00;
endpackage

/* rtl/aise_flag_if.sv */
// Interface between the register front end and a sticky flag store
interface aise_flag_if #(parameter int W = 8);
    logic [W-1:0] set;
    logic rd_clr;
    logic [W-1:0] q;
    modport store (input set, input rd_clr, output q);
    modport user (output set, output rd_clr, input q);
endinterface

/* rtl/aise_flags.sv */
// Sticky read-clear flag store; a set in the clearing cycle wins
module aise_flags #(
    parameter int W = 8,
    parameter logic [W-1:0] VALID = '1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    aise_flag_if.store f
);
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    for (genvar i = 0; i < W; i++) begin : g_bit
        assign q_nxt[i] = VALID[i] & (f.set[i] | (q_r[i] & ~f.rd_clr));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_r <= RST_VAL;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign f.q = q_r;
endmodule

/* rtl/aise_top.sv */
// ADC interrupt enable and event flag registers behind a classic Wishbone slave
//
// Local design decision: register access over Wishbone.

module aise_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [aise_pkg::IDX_W+1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    input wire logic calibration_complete_i,
    input wire logic input_out_of_range_i,
    input wire logic temp_cal_out_of_date_i,
    input wire logic low_threshold_i,
    input wire logic high_threshold_i,
    input wire logic ref_ready_i,
    input wire logic conversion_done_i,
    input wire logic ref_limit_i,
    input wire logic ref_limit_scale1_i,
    input wire logic ref_limit_scale2_i,
    input wire logic ref_limit_scale3_i,
    input wire logic temp_sensor_error_i,
    output logic ref_limit_irq_en_o,
    output logic ref_limit_scale1_irq_en_o,
    output logic ref_limit_scale2_irq_en_o,
    output logic ref_limit_scale3_irq_en_o,
    output logic temp_sensor_error_irq_en_o
);
    localparam int RW = aise_pkg::REG_W;

    logic [RW-1:0] enable_r;
    logic [RW-1:0] enable_nxt;
    logic [RW-1:0] flag_mask_r;
    logic [RW-1:0] flag_mask_nxt;
    logic ack_r;
    logic [RW-1:0] rdata_r;
    logic irq_r;

    aise_flag_if #(.W(RW)) evt_if ();
    aise_flag_if #(.W(RW)) st_if ();

    // Bus decode
    wire [aise_pkg::IDX_W-1:0] idx = wb_adr_i[aise_pkg::IDX_W+1:2];
    wire req = wb_cyc_i & wb_stb_i & ~ack_r;
    wire wr_fire = req & wb_we_i & wb_sel_i[0];
    wire rd_fire = req & ~wb_we_i;
    wire hit_enable = idx == aise_pkg::IDX_IRQ_ENABLE;
    wire hit_flags = idx == aise_pkg::IDX_EVENT_FLAGS;
    wire hit_mask = idx == aise_pkg::IDX_FLAG_MASK;
    wire hit_status = idx == aise_pkg::IDX_SELFTEST_STATUS;
    wire wr_enable = wr_fire & hit_enable;
    wire wr_mask = wr_fire & hit_mask;
    wire rd_flags = rd_fire & hit_flags;
    wire rd_status = rd_fire & hit_status;

    // Read mux; unmapped addresses read zero
    wire [RW-1:0] rmux =
        hit_enable ? enable_r :
        hit_flags ? evt_if.q :
        hit_mask ? flag_mask_r :
        hit_status ? st_if.q :
        8'h00;

    // Reserved enable bits stay zero
    assign enable_nxt = wr_enable ? (wb_dat_i[RW-1:0] & aise_pkg::ENABLE_VALID) : enable_r;
    assign flag_mask_nxt = wr_mask ? (wb_dat_i[RW-1:0] & aise_pkg::FLAGS_VALID) : flag_mask_r;

    // Event flag sources
    assign evt_if.set[aise_pkg::BIT_CALIBRATION_COMPLETE] = calibration_complete_i;
    assign evt_if.set[aise_pkg::BIT_INPUT_OUT_OF_RANGE] = input_out_of_range_i;
    assign evt_if.set[aise_pkg::BIT_TEMP_CAL_OUT_OF_DATE] = temp_cal_out_of_date_i;
    assign evt_if.set[4] = 1'b0;
    assign evt_if.set[aise_pkg::BIT_LOW_THRESHOLD] = low_threshold_i;
    assign evt_if.set[aise_pkg::BIT_HIGH_THRESHOLD] = high_threshold_i;
    assign evt_if.set[aise_pkg::BIT_REF_READY] = ref_ready_i;
    assign evt_if.set[aise_pkg::BIT_CONVERSION_DONE] = conversion_done_i;
    assign evt_if.rd_clr = rd_flags;

    // Self-test status, same layout as the enable register
    assign st_if.set[7] = 1'b0;
    assign st_if.set[aise_pkg::BIT_REF_LIMIT_IRQ_EN] = ref_limit_i;
    assign st_if.set[aise_pkg::BIT_REF_LIMIT_SCALE1_IRQ_EN] = ref_limit_scale1_i;
    assign st_if.set[aise_pkg::BIT_REF_LIMIT_SCALE2_IRQ_EN] = ref_limit_scale2_i;
    assign st_if.set[aise_pkg::BIT_REF_LIMIT_SCALE3_IRQ_EN] = ref_limit_scale3_i;
    assign st_if.set[2] = 1'b0;
    assign st_if.set[aise_pkg::BIT_TEMP_SENSOR_ERROR_IRQ_EN] = temp_sensor_error_i;
    assign st_if.set[0] = 1'b0;
    assign st_if.rd_clr = rd_status;

    aise_flags #(
        .W(RW),
        .VALID(aise_pkg::FLAGS_VALID),
        .RST_VAL(aise_pkg::FLAGS_RST)
    ) u_event_flags (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .f(evt_if.store)
    );

    aise_flags #(
        .W(RW),
        .VALID(aise_pkg::ENABLE_VALID),
        .RST_VAL(aise_pkg::FLAGS_RST)
    ) u_selftest_status (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .f(st_if.store)
    );

    // Enabled self-test sources and unmasked event flags
    wire st_pending = |(st_if.q & enable_r);
    wire evt_pending = |(evt_if.q & flag_mask_r);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_r <= aise_pkg::ENABLE_RST;
            flag_mask_r <= aise_pkg::FLAG_MASK_RST;
        end else begin
            enable_r <= enable_nxt;
            flag_mask_r <= flag_mask_nxt;
        end
    end

    // One-cycle acknowledge, data captured with it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            ack_r <= req;
            rdata_r <= rd_fire ? rmux : 8'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= st_pending | evt_pending;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = {24'h000000, rdata_r};
    assign irq_o = irq_r;
    assign ref_limit_irq_en_o = enable_r[aise_pkg::BIT_REF_LIMIT_IRQ_EN];
    assign ref_limit_scale1_irq_en_o = enable_r[aise_pkg::BIT_REF_LIMIT_SCALE1_IRQ_EN];
    assign ref_limit_scale2_irq_en_o = enable_r[aise_pkg::BIT_REF_LIMIT_SCALE2_IRQ_EN];
    assign ref_limit_scale3_irq_en_o = enable_r[aise_pkg::BIT_REF_LIMIT_SCALE3_IRQ_EN];
    assign temp_sensor_error_irq_en_o = enable_r[aise_pkg::BIT_TEMP_SENSOR_ERROR_IRQ_EN];

    // Checks
    a_enable_write: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_enable |=> (enable_r == ($past(wb_dat_i[RW-1:0]) & aise_pkg::ENABLE_VALID))
    ) else $error("enable register did not take written value");

    a_enable_hold: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !wr_enable |=> $stable(enable_r)
    ) else $error("enable register changed without a write");

    a_lo_flag_set: assert property (
        @(posedge clk_i) disable iff (rst_i)
        low_threshold_i |=> evt_if.q[aise_pkg::BIT_LOW_THRESHOLD]
    ) else $error("low threshold event not flagged");

    a_lo_flag_clear: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (rd_flags && !low_threshold_i) |=> !evt_if.q[aise_pkg::BIT_LOW_THRESHOLD]
    ) else $error("low threshold flag not cleared by read");

    a_hi_flag_cycle: assert property (
        @(posedge clk_i) disable iff (rst_i)
        high_threshold_i ##1 (rd_flags && !high_threshold_i)
        |=> (rdata_r[aise_pkg::BIT_HIGH_THRESHOLD] && !evt_if.q[aise_pkg::BIT_HIGH_THRESHOLD])
    ) else $error("high threshold flag not read as set then cleared");

    a_ready_flag: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ref_ready_i ##1 (!ref_ready_i && !rd_flags)[*2]
        |-> evt_if.q[aise_pkg::BIT_REF_READY]
    ) else $error("ready flag lost before a read");

    a_done_flag: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (rd_flags && !conversion_done_i) ##1 (!conversion_done_i)[*3]
        |-> !evt_if.q[aise_pkg::BIT_CONVERSION_DONE]
    ) else $error("conversion done flag reappeared without an event");

    a_range_flag: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $rose(evt_if.q[aise_pkg::BIT_INPUT_OUT_OF_RANGE]) |-> $past(input_out_of_range_i)
    ) else $error("out of range flag rose without cause");

    a_ood_flag: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (temp_cal_out_of_date_i && rd_flags) |=> evt_if.q[aise_pkg::BIT_TEMP_CAL_OUT_OF_DATE]
    ) else $error("calibration stale event lost during read");

    a_flag_readback: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_flags |=> (wb_ack_o && wb_dat_o[RW-1:0] == $past(evt_if.q))
    ) else $error("flag read did not return stored flags");

    a_flag_reserved: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_fire && hit_flags |=> ((evt_if.q & ~$past(evt_if.q | evt_if.set)) == 8'h00)
    ) else $error("write changed read-only flags");

    a_irq_follow: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (st_pending || evt_pending) |=> irq_o
    ) else $error("interrupt not raised for pending source");

    a_ack_single: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o
    ) else $error("acknowledge held longer than one cycle");

    a_mask_write: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_mask |=> (flag_mask_r == ($past(wb_dat_i[RW-1:0]) & aise_pkg::FLAGS_VALID))
    ) else $error("mask register did not take written value");

    a_mask_hold: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !wr_mask |=> $stable(flag_mask_r)
    ) else $error("mask register changed without a write");

    a_enable_spare: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (enable_r & ~aise_pkg::ENABLE_VALID) == 8'h00
    ) else $error("reserved enable bit set");

    a_flag_spare: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (evt_if.q & ~aise_pkg::FLAGS_VALID) == 8'h00
    ) else $error("reserved flag bit set");

    a_cal_flag_set: assert property (
        @(posedge clk_i) disable iff (rst_i)
        calibration_complete_i |=> evt_if.q[aise_pkg::BIT_CALIBRATION_COMPLETE]
    ) else $error("calibration complete event not flagged");

    a_range_flag_set: assert property (
        @(posedge clk_i) disable iff (rst_i)
        input_out_of_range_i |=> evt_if.q[aise_pkg::BIT_INPUT_OUT_OF_RANGE]
    ) else $error("out of range event not flagged");

    a_ood_flag_set: assert property (
        @(posedge clk_i) disable iff (rst_i)
        temp_cal_out_of_date_i |=> evt_if.q[aise_pkg::BIT_TEMP_CAL_OUT_OF_DATE]
    ) else $error("calibration stale event not flagged");

    a_hi_flag_set: assert property (
        @(posedge clk_i) disable iff (rst_i)
        high_threshold_i |=> evt_if.q[aise_pkg::BIT_HIGH_THRESHOLD]
    ) else $error("high threshold event not flagged");

    a_ready_flag_set: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ref_ready_i |=> evt_if.q[aise_pkg::BIT_REF_READY]
    ) else $error("ready event not flagged");

    a_done_flag_set: assert property (
        @(posedge clk_i) disable iff (rst_i)
        conversion_done_i |=> evt_if.q[aise_pkg::BIT_CONVERSION_DONE]
    ) else $error("conversion done event not flagged");

    a_hi_flag_clear: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (rd_flags && !high_threshold_i) |=> !evt_if.q[aise_pkg::BIT_HIGH_THRESHOLD]
    ) else $error("high threshold flag not cleared by read");

    a_ready_flag_clear: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (rd_flags && !ref_ready_i) |=> !evt_if.q[aise_pkg::BIT_REF_READY]
    ) else $error("ready flag not cleared by read");

    a_done_flag_clear: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (rd_flags && !conversion_done_i) |=> !evt_if.q[aise_pkg::BIT_CONVERSION_DONE]
    ) else $error("conversion done flag not cleared by read");

    a_ood_flag_clear: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (rd_flags && !temp_cal_out_of_date_i) |=> !evt_if.q[aise_pkg::BIT_TEMP_CAL_OUT_OF_DATE]
    ) else $error("calibration stale flag not cleared by read");

    a_flag_sticky: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !rd_flags |=> ((evt_if.q & $past(evt_if.q)) == $past(evt_if.q))
    ) else $error("flag dropped without a read");

    a_flag_cause: assert property (
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> ((evt_if.q & ~$past(evt_if.q) & ~$past(evt_if.set)) == 8'h00)
    ) else $error("flag rose without its event");

    a_status_set: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (st_if.set != 8'h00) |=> ((st_if.q & $past(st_if.set)) == ($past(st_if.set) & aise_pkg::ENABLE_VALID))
    ) else $error("self-test event not recorded");

    a_status_clear: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (rd_status && st_if.set == 8'h00) |=> (st_if.q == 8'h00)
    ) else $error("self-test status not cleared by read");

    a_status_readonly: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wr_fire && hit_status) |=> ((st_if.q & ~$past(st_if.q | st_if.set)) == 8'h00)
    ) else $error("write changed self-test status");

    a_irq_quiet: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !(st_pending || evt_pending) |=> !irq_o
    ) else $error("interrupt raised with nothing pending");

    a_ack_after_req: assert property (
        @(posedge clk_i) disable iff (rst_i)
        req |=> wb_ack_o
    ) else $error("request not acknowledged in the next cycle");

    a_ack_needs_req: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !req |=> !wb_ack_o
    ) else $error("acknowledge without a request");

    a_enable_read: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (rd_fire && hit_enable) |=> (wb_dat_o[RW-1:0] == $past(enable_r))
    ) else $error("enable read did not return stored value");

    a_mask_read: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (rd_fire && hit_mask) |=> (wb_dat_o[RW-1:0] == $past(flag_mask_r))
    ) else $error("mask read did not return stored value");

    a_unmapped_read: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (rd_fire && !(hit_enable || hit_flags || hit_mask || hit_status)) |=> (wb_dat_o == 32'h00000000)
    ) else $error("unmapped read returned nonzero data");
endmodule

/* tb/test_adc_interrupt_status_enable.sv */
// Register-level testbench for the ADC interrupt enable and event flag block
module test_adc_interrupt_status_enable;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] A_EN = 16'h143c;
    localparam logic [15:0] A_FL = 16'h1440;
    localparam logic [15:0] A_MK = 16'h1480;
    localparam logic [15:0] A_ST = 16'h1484;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] sel = 4'h1;
    logic [15:0] adr = 16'h0000;
    logic [31:0] dat = 32'h00000000;
    logic [7:0] ev = 8'h00;
    logic [7:0] st = 8'h00;
    logic [7:0] q;
    wire [31:0] dat_o;
    wire ack;
    wire irq;
    wire [4:0] en_o;
    int bad_count = 0;
    int cmp_count = 0;
    int fb[7] = '{0, 1, 2, 3, 5, 6, 7};

    always #2 clk_i = ~clk_i;

    aise_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_o(irq),
        .calibration_complete_i(ev[7]), .input_out_of_range_i(ev[6]), .temp_cal_out_of_date_i(ev[5]),
        .low_threshold_i(ev[3]), .high_threshold_i(ev[2]), .ref_ready_i(ev[1]), .conversion_done_i(ev[0]),
        .ref_limit_i(st[6]), .ref_limit_scale1_i(st[5]), .ref_limit_scale2_i(st[4]), .ref_limit_scale3_i(st[3]),
        .temp_sensor_error_i(st[1]), .ref_limit_irq_en_o(en_o[4]), .ref_limit_scale1_irq_en_o(en_o[3]),
        .ref_limit_scale2_irq_en_o(en_o[2]), .ref_limit_scale3_irq_en_o(en_o[1]),
        .temp_sensor_error_irq_en_o(en_o[0]));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One classic cycle; ack sampled at the edge, then released
    task automatic bus(input logic [15:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        chk("ack", 8'h01, {7'h00, ack});
        q = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
        bus(a, 1'b0, 8'h00);
        chk(what, exp, q);
    endtask

    task automatic pulse(input int b, input bit selftest);
        @(posedge clk_i);
        if (selftest) st[b] <= 1'b1;
        else ev[b] <= 1'b1;
        @(posedge clk_i);
        st <= 8'h00;
        ev <= 8'h00;
        repeat (3) @(posedge clk_i);
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        #20000;
        bad_count++;
        $display("watchdog expired");
        results;
    end

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(A_EN, 8'h00, "enable reset");
        rd(A_FL, 8'h00, "flags reset");
        chk("irq reset", 8'h00, {7'h00, irq});
        $display("test reset done");
        bus(A_EN, 1'b1, 8'hff);
        rd(A_EN, 8'h7a, "enable all");
        chk("enable outputs", 8'h1f, {3'h0, en_o});
        bus(A_EN, 1'b1, 8'h00);
        rd(A_EN, 8'h00, "enable none");
        chk("enable outputs off", 8'h00, {3'h0, en_o});
        sel <= 4'he;
        bus(A_EN, 1'b1, 8'hff);
        sel <= 4'h1;
        rd(A_EN, 8'h00, "enable low lane off");
        $display("test enable done");
        foreach (fb[i]) begin
            pulse(fb[i], 1'b0);
            rd(A_FL, 8'h01 << fb[i], "flag set");
            rd(A_FL, 8'h00, "flag cleared");
        end
        // Event just before a read, and another in the read cycle itself
        @(posedge clk_i);
        ev[2] <= 1'b1;
        fork
            rd(A_FL, 8'h04, "flag set just before read");
            begin
                @(posedge clk_i);
                ev <= 8'h20;
                @(posedge clk_i);
                ev <= 8'h00;
            end
        join
        rd(A_FL, 8'h20, "event at read kept");
        pulse(2, 1'b0);
        bus(A_FL, 1'b1, 8'h00);
        rd(A_FL, 8'h04, "flag after write");
        bus(A_FL, 1'b1, 8'hff);
        rd(A_FL, 8'h00, "flag write ignored");
        rd(16'h1444, 8'h00, "unmapped read");
        $display("test flags done");
        pulse(3, 1'b0);
        chk("irq masked", 8'h00, {7'h00, irq});
        rd(A_FL, 8'h08, "masked flag");
        bus(A_MK, 1'b1, 8'h08);
        rd(A_MK, 8'h08, "mask readback");
        pulse(3, 1'b0);
        chk("irq unmasked", 8'h01, {7'h00, irq});
        rd(A_FL, 8'h08, "unmasked flag");
        repeat (2) @(posedge clk_i);
        chk("irq after read", 8'h00, {7'h00, irq});
        $display("test interrupt done");
        bus(A_ST, 1'b1, 8'hff);
        rd(A_ST, 8'h00, "status write ignored");
        pulse(6, 1'b1);
        chk("irq source disabled", 8'h00, {7'h00, irq});
        rd(A_ST, 8'h40, "selftest status");
        bus(A_EN, 1'b1, 8'h40);
        pulse(6, 1'b1);
        chk("irq source enabled", 8'h01, {7'h00, irq});
        rd(A_ST, 8'h40, "selftest set");
        rd(A_ST, 8'h00, "selftest cleared");
        repeat (2) @(posedge clk_i);
        chk("irq selftest cleared", 8'h00, {7'h00, irq});
        $display("test selftest done");
        results;
    end
endmodule
